/* File: bench/pad_field.sv */
// pad model: resolves the twelve line pads from the unit and external drivers
// assumes undriven pads sit low through their pull-downs
`timescale 1ns/100ps
module pad_field
(
  input wire logic [11:0] i_line_out,
  input wire logic [11:0] i_line_oe,
  input wire logic [11:0] i_ext_level,
  input wire logic [11:0] i_ext_drive,
  output logic [11:0] o_pad
);
  // ****************************************
  // resolution
  // ****************************************
  // external drive is only used where the unit does not drive, so no contention
  assign o_pad = (i_line_oe & i_line_out) | (~i_line_oe & i_ext_drive & i_ext_level);
endmodule

/* File: bench/test_programmable_io_with_trip.sv */
// self-checking bench for the programmable i/o unit
// assumes the unit answers axi4-lite itself; pads resolved by pad_field
`timescale 1ns/100ps
module test_programmable_io_with_trip;
  import io_trip_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] ext_level = 12'h000;
  logic [11:0] ext_drive = 12'h000;
  logic [11:0] pad, line_out, line_oe;
  logic awready, wready, bvalid, arready, rvalid, pwm_off, vec_ok, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [13:0] vector;
  irq_bundle_t intr;
  logic [33:0] rd_q[$];
  int fails = 0;
  int samples_checked = 0;
  logic [11:0] dir, dat;
  logic [7:0] ofs [8];
  wire [3:0] probes = {irq, vec_ok, intr.group, 1'b0};

  programmable_io_with_trip dut (.i_core_clk(core_clk), .i_reset_n(reset_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_line_in(pad), .o_line_out(line_out), .o_line_oe(line_oe),
    .o_pwm_shutdown(pwm_off), .o_intr(intr), .o_vector(vector),
    .o_vector_valid(vec_ok), .o_irq(irq));

  pad_field pads (.i_line_out(line_out), .i_line_oe(line_oe), .i_ext_level(ext_level),
    .i_ext_drive(ext_drive), .o_pad(pad));

  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic timeout_hit();
    fails++;
    tally_and_finish();
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wait_probe(input int k);
    int n;
    n = 0;
    while (probes[k] !== 1'b1)
    begin
      @(posedge core_clk);
      n++;
      if (n > 200)
        timeout_hit();
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (n > 200)
        timeout_hit();
    end
    while (bvalid !== 1'b1);
    check(32'(bresp), 32'(r));
    bready <= 1'b0;
  endtask

  // expectation is queued here; the monitor below compares it
  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    rd_q.push_back({r, d});
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (n > 200)
        timeout_hit();
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, RESP_OKAY);
  endtask

  always @(posedge core_clk)
  begin
    if (rvalid === 1'b1 && rready && rd_q.size() > 0)
    begin
      check(rdata, rd_q[0][31:0]);
      check(32'(rresp), 32'(rd_q[0][33:32]));
      void'(rd_q.pop_front());
    end
    else if (rvalid === 1'b1 && rready)
      check(32'(rvalid), 32'h0);
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    void'($urandom(9432));
    ofs = '{OFS_DIRECTION, OFS_DATA, OFS_GROUP_EN, OFS_SENSE, OFS_POLARITY,
      OFS_SHUTDOWN_EN, OFS_CTRL_MASK, OFS_IRQ_ENABLE};
    cycles(16);
    reset_n <= 1'b1;
    cycles(3);
    for (int i = 0; i < 8; i++)
      axi_read(ofs[i], (ofs[i] == OFS_SHUTDOWN_EN) ? 32'hFFF : 32'h0, RESP_OKAY);
    check(32'(pwm_off), 32'h1);
    axi_read(8'h3C, 32'h0, RESP_SLVERR);
    axi_write(8'h40, 32'h1, RESP_SLVERR);
    // pwm trip through one line
    ext_drive[5] <= 1'b1;
    ext_level[5] <= 1'b1;
    wr(OFS_SHUTDOWN_EN, 32'h020);
    wr(OFS_IRQ_CLEAR, 32'h3F);
    check(32'(pwm_off), 32'h0);
    ext_level[5] <= 1'b0;
    #1;
    check(32'(pwm_off), 32'h1);
    cycles(6);
    axi_read(OFS_IRQ_STATUS, 32'h20, RESP_OKAY);
    wr(OFS_SHUTDOWN_EN, 32'h000);
    ext_drive <= 12'h000;
    // direction and data with random values
    for (int i = 0; i < 3; i++)
    begin
      dir = 12'($urandom);
      dat = 12'($urandom);
      ext_level <= 12'($urandom);
      ext_drive <= ~dir;
      wr(OFS_DIRECTION, 32'(dir));
      wr(OFS_DATA, 32'(dat));
      cycles(4);
      check(32'(line_oe), 32'(dir));
      check(32'(line_out), 32'(dat & dir));
      axi_read(OFS_DATA, 32'((ext_level & ~dir) | (dat & dir)), RESP_OKAY);
    end
    // only the upper byte lane is written, lines 0 to 7 keep their direction
    wstrb <= 4'h2;
    wr(OFS_DIRECTION, 32'hFFF);
    wstrb <= 4'hF;
    axi_read(OFS_DIRECTION, 32'({4'hF, dir[7:0]}), RESP_OKAY);
    ext_drive <= 12'h000;
    wr(OFS_DIRECTION, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h3F);
    // dedicated lines, rising edge
    wr(OFS_POLARITY, 32'hFFF);
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_CTRL_MASK, 32'h1 << k);
      ext_drive[k] <= 1'b1;
      ext_level[k] <= 1'b1;
      wait_probe(2);
      check(32'(vector), 32'(14'h0048 + 14'(4 * k)));
      ext_drive[k] <= 1'b0;
      cycles(5);
    end
    // level high on an output line loops back
    wr(OFS_CTRL_MASK, 32'h02);
    wr(OFS_SENSE, 32'h002);
    wr(OFS_DIRECTION, 32'h002);
    wr(OFS_DATA, 32'h002);
    cycles(8);
    check(32'(intr.line), 32'h2);
    wr(OFS_DATA, 32'h000);
    cycles(6);
    check(32'(intr.line), 32'h0);
    wr(OFS_SENSE, 32'h000);
    wr(OFS_DIRECTION, 32'h000);
    // shared group, falling edge; line 7 stays disabled
    wr(OFS_POLARITY, 32'h000);
    wr(OFS_GROUP_EN, 32'h040);
    wr(OFS_CTRL_MASK, 32'h10);
    ext_drive <= 12'h0C0;
    ext_level <= 12'h0C0;
    cycles(6);
    ext_level <= 12'h000;
    wait_probe(2);
    check(32'(vector), 32'h003C);
    check(32'(intr.group), 32'h1);
    axi_read(OFS_GROUP_FLAGS, 32'h040, RESP_OKAY);
    axi_read(OFS_GROUP_FLAGS, 32'h000, RESP_OKAY);
    ext_drive <= 12'h000;
    // status, enable and clear of the interrupt output
    wr(OFS_IRQ_CLEAR, 32'h3F);
    wr(OFS_POLARITY, 32'hFFF);
    wr(OFS_CTRL_MASK, 32'h01);
    ext_drive[0] <= 1'b1;
    ext_level[0] <= 1'b1;
    wait_probe(2);
    cycles(4);
    check(32'(irq), 32'h0);
    axi_read(OFS_IRQ_STATUS, 32'h01, RESP_OKAY);
    wr(OFS_IRQ_ENABLE, 32'h01);
    wait_probe(3);
    wr(OFS_IRQ_CLEAR, 32'h01);
    cycles(3);
    check(32'(irq), 32'h0);
    // falling edge on a dedicated line
    wr(OFS_POLARITY, 32'h000);
    ext_drive[0] <= 1'b0;
    wait_probe(2);
    check(32'(vector), 32'h0048);
    tally_and_finish();
  end
endmodule

/* File: rtl/io_trip_pkg.sv */
// constants, register map and carrier types for the programmable i/o unit
// assumes a 32-bit axi4-lite master and twelve pad lines with pull-downs
package io_trip_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int LINES = 12;
  localparam int DEDICATED = 4;
  localparam int IRQ_SRC = 6;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_DIRECTION = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_GROUP_EN = 8'h08;
  localparam logic [7:0] OFS_SENSE = 8'h0C;
  localparam logic [7:0] OFS_POLARITY = 8'h10;
  localparam logic [7:0] OFS_GROUP_FLAGS = 8'h14;
  localparam logic [7:0] OFS_SHUTDOWN_EN = 8'h18;
  localparam logic [7:0] OFS_CTRL_MASK = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [11:0] RST_DIRECTION = 12'h000;
  localparam logic [11:0] RST_DATA = 12'h000;
  localparam logic [11:0] RST_GROUP_EN = 12'h000;
  localparam logic [11:0] RST_SENSE = 12'h000;
  localparam logic [11:0] RST_POLARITY = 12'h000;
  localparam logic [11:0] RST_SHUTDOWN_EN = 12'hFFF;
  localparam logic [4:0] RST_CTRL_MASK = 5'h00;
  localparam logic [5:0] RST_IRQ_ENABLE = 6'h00;

  // ****************************************
  // controller mask / status bit positions and vectors
  // ****************************************
  localparam int BIT_GROUP = 4;
  localparam int BIT_TRIP = 5;
  localparam logic [13:0] VEC_LINE_BASE = 14'h0048;
  localparam logic [13:0] VEC_LINE_STEP = 14'h0004;
  localparam logic [13:0] VEC_GROUP = 14'h003C;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [11:0] dir;
    logic [11:0] data;
    logic [11:0] grp_en;
    logic [11:0] sense;
    logic [11:0] pol;
    logic [11:0] shut_en;
    logic [4:0] mask;
  } line_cfg_t;

  typedef struct packed {
    logic [3:0] line;
    logic group;
    logic trip;
  } irq_bundle_t;

endpackage

/* File: rtl/programmable_io_with_trip.sv */
// twelve-line programmable i/o unit with interrupt detection and pwm trip
// assumes an axi4-lite master on i_core_clk and pads resolved outside
// Summary of operation
// RL1 - direction bit 0 makes a line input, 1 drives it as output
// RL2 - reset clears all direction bits so every line starts as input
// RL3 - written data is driven onto lines set as outputs
// RL4 - data register read returns pin levels of input lines
// RL5 - lines 0-3 own interrupts; lines 4-11 share one group interrupt
// RL6 - group enable gates lines 4-11; controller mask gates five interrupts
// RL7 - sense bit 1 detects by level, 0 detects by edge
// RL8 - polarity 1 means high or rising, 0 means low or falling
// RL9 - after reset no line generates interrupts; low pins still raise the trip interrupt via the set shutdown enables
// RL10 - lines 0-3 vector to 0x0048, 0x004C, 0x0050, 0x0054
// RL11 - enabled hit on lines 4-11 sets its flag and group interrupt 0x003C
// RL12 - detection also works on lines driven as outputs
// RL13 - enabled low pin shuts down all pwm outputs without the clock
// RL14 - a line shutdown also raises the pwm trip interrupt
// RL15 - reset sets every shutdown enable bit
// RL16 - bit n of every twelve-bit register concerns only line n
// RL17 - software must configure lines before using the pwm
// RL18 - each pin passes a two-stage synchroniser before detection and data reads; the shutdown path takes it raw
// RL19 - reading group flags clears them; flags raised that cycle survive
`timescale 1ns/100ps
module programmable_io_with_trip
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [io_trip_pkg::LINES-1:0] i_line_in,
  output logic [io_trip_pkg::LINES-1:0] o_line_out,
  output logic [io_trip_pkg::LINES-1:0] o_line_oe,
  output logic o_pwm_shutdown,
  output io_trip_pkg::irq_bundle_t o_intr,
  output logic [13:0] o_vector,
  output logic o_vector_valid,
  output logic o_irq
);
  import io_trip_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [11:0] merge12(logic [11:0] old, logic [31:0] wd, logic [3:0] st);
    logic [11:0] r;
    r = old;
    if (st[0])
      r[7:0] = wd[7:0];
    if (st[1])
      r[11:8] = wd[11:8];
    return r;
  endfunction

  function automatic logic mapped(logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_IRQ_ENABLE);
  endfunction

  // ****************************************
  // pin synchroniser and detection
  // ****************************************
  logic [11:0] sync1_q, sync2_q, prev_q;
  logic [11:0] hit;

  // see RL18
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 12'h000;
      sync2_q <= 12'h000;
      prev_q <= 12'h000;
    end
    else
    begin
      sync1_q <= i_line_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  line_cfg_t cfg_q;

  // pad level is watched, not direction, so output lines trigger too (see RL12)
  for (genvar n = 0; n < LINES; n++)
  begin : g_detect
    // see RL16
    always_comb
    begin
      if (cfg_q.sense[n])
        hit[n] = (sync2_q[n] == cfg_q.pol[n]); // see RL7, see RL8
      else if (cfg_q.pol[n])
        hit[n] = sync2_q[n] & ~prev_q[n];
      else
        hit[n] = ~sync2_q[n] & prev_q[n];
    end
  end

  // ****************************************
  // pwm shutdown path
  // ****************************************
  // deliberately combinational: it must act even with the core clock stopped
  assign o_pwm_shutdown = |(~i_line_in & cfg_q.shut_en); // see RL13

  logic trip_s1_q, trip_s2_q, trip_prev_q;

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trip_s1_q <= 1'b0;
      trip_s2_q <= 1'b0;
      trip_prev_q <= 1'b0;
    end
    else
    begin
      trip_s1_q <= o_pwm_shutdown;
      trip_s2_q <= trip_s1_q;
      trip_prev_q <= trip_s2_q;
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  logic aw_full_q, w_full_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;

  assign do_write = aw_full_q & w_full_q & ~o_bvalid;

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end
    else
    begin
      if (o_awready && i_awvalid)
      begin
        aw_full_q <= 1'b1;
        waddr_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (o_wready && i_wvalid)
      begin
        w_full_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic [5:0] irq_en_q;
  logic [5:0] irq_clr;

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q.dir <= RST_DIRECTION; // see RL2
      cfg_q.data <= RST_DATA;
      cfg_q.grp_en <= RST_GROUP_EN; // see RL9
      cfg_q.sense <= RST_SENSE;
      cfg_q.pol <= RST_POLARITY;
      cfg_q.shut_en <= RST_SHUTDOWN_EN; // see RL15
      cfg_q.mask <= RST_CTRL_MASK;
      irq_en_q <= RST_IRQ_ENABLE;
    end
    else if (do_write)
    begin
      unique case (waddr_q)
        OFS_DIRECTION: cfg_q.dir <= merge12(cfg_q.dir, wdata_q, wstrb_q);
        OFS_DATA: cfg_q.data <= merge12(cfg_q.data, wdata_q, wstrb_q);
        OFS_GROUP_EN: cfg_q.grp_en <= merge12(cfg_q.grp_en, wdata_q, wstrb_q);
        OFS_SENSE: cfg_q.sense <= merge12(cfg_q.sense, wdata_q, wstrb_q);
        OFS_POLARITY: cfg_q.pol <= merge12(cfg_q.pol, wdata_q, wstrb_q);
        OFS_SHUTDOWN_EN: cfg_q.shut_en <= merge12(cfg_q.shut_en, wdata_q, wstrb_q);
        OFS_CTRL_MASK:
        begin
          if (wstrb_q[0])
            cfg_q.mask <= wdata_q[4:0];
        end
        OFS_IRQ_ENABLE:
        begin
          if (wstrb_q[0])
            irq_en_q <= wdata_q[5:0];
        end
        default: ;
      endcase
    end
  end

  assign irq_clr = (do_write && waddr_q == OFS_IRQ_CLEAR && wstrb_q[0]) ? wdata_q[5:0] : 6'h00;

  // see RL1, see RL3
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_line_oe <= RST_DIRECTION;
      o_line_out <= RST_DATA;
    end
    else
    begin
      o_line_oe <= cfg_q.dir;
      o_line_out <= cfg_q.data & cfg_q.dir;
    end
  end

  // ****************************************
  // group flags and interrupt lines
  // ****************************************
  logic [11:0] flags_q;
  logic flag_read;
  logic [11:0] grp_hit;

  assign grp_hit = {hit[11:4] & cfg_q.grp_en[11:4], 4'h0}; // see RL6
  assign flag_read = o_arready & i_arvalid & (i_araddr == OFS_GROUP_FLAGS);

  // a hit in the reading cycle outlives the clear (see RL19)
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_q <= 12'h000;
    else
      flags_q <= (flag_read ? 12'h000 : flags_q) | grp_hit; // see RL11
  end

  // see RL5, see RL6, see RL14
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_intr <= '0;
    else
    begin
      o_intr.line <= hit[3:0] & cfg_q.mask[3:0];
      o_intr.group <= cfg_q.mask[BIT_GROUP] & (|flags_q);
      o_intr.trip <= trip_s2_q & ~trip_prev_q;
    end
  end

  // line 0 has the highest priority, the group vector the lowest
  function automatic logic [13:0] pick_vector(irq_bundle_t b);
    logic [13:0] v;
    v = VEC_GROUP;
    for (int k = DEDICATED - 1; k >= 0; k--)
    begin
      if (b.line[k])
        v = VEC_LINE_BASE + VEC_LINE_STEP * 14'(k);
    end
    return v;
  endfunction

  // see RL10, see RL11
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_vector <= VEC_GROUP;
      o_vector_valid <= 1'b0;
    end
    else
    begin
      o_vector <= pick_vector(o_intr);
      o_vector_valid <= (|o_intr.line) | o_intr.group;
    end
  end

  // ****************************************
  // sticky status and summary interrupt
  // ****************************************
  logic [5:0] status_q;

  // set wins over a clear in the same cycle
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= 6'h00;
      o_irq <= 1'b0;
    end
    else
    begin
      status_q <= (status_q & ~irq_clr) | {o_intr.trip, o_intr.group, o_intr.line};
      o_irq <= |(status_q & irq_en_q);
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (i_araddr)
      OFS_DIRECTION: rd_mux[11:0] = cfg_q.dir;
      OFS_DATA: rd_mux[11:0] = (sync2_q & ~cfg_q.dir) | (cfg_q.data & cfg_q.dir); // see RL4
      OFS_GROUP_EN: rd_mux[11:0] = cfg_q.grp_en;
      OFS_SENSE: rd_mux[11:0] = cfg_q.sense;
      OFS_POLARITY: rd_mux[11:0] = cfg_q.pol;
      OFS_GROUP_FLAGS: rd_mux[11:0] = flags_q;
      OFS_SHUTDOWN_EN: rd_mux[11:0] = cfg_q.shut_en;
      OFS_CTRL_MASK: rd_mux[4:0] = cfg_q.mask;
      OFS_IRQ_STATUS: rd_mux[5:0] = status_q;
      OFS_IRQ_ENABLE: rd_mux[5:0] = irq_en_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end
    else
    begin
      if (o_arready && i_arvalid)
      begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_mux;
        o_rresp <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (o_rvalid && i_rready)
      begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_full_write(logic [7:0] ofs);
    do_write && waddr_q == ofs && wstrb_q[1:0] == 2'h3;
  endsequence

  sequence s_sd_rise;
    !o_pwm_shutdown ##1 o_pwm_shutdown [*3];
  endsequence

  chk_dir_write: assert property (@(posedge i_core_clk) disable iff (!rst_n) // see RL1
    s_full_write(OFS_DIRECTION) |=> ##1 o_line_oe == $past(wdata_q[11:0], 2))
    else $error("direction write not reflected on output enables");
  chk_data_drive: assert property (@(posedge i_core_clk) disable iff (!rst_n) // see RL3
    s_full_write(OFS_DATA) |=> ##1 o_line_out == ($past(wdata_q[11:0], 2) & o_line_oe))
    else $error("data write not driven on output lines");
  chk_read_inputs: assert property (@(posedge i_core_clk) disable iff (!rst_n) // see RL4
    (o_arready && i_arvalid && i_araddr == OFS_DATA)
    |=> (o_rdata[11:0] & ~$past(cfg_q.dir)) == ($past(sync2_q) & ~$past(cfg_q.dir)))
    else $error("data read does not show input pin levels");
  chk_line_fall_irq: assert property (@(posedge i_core_clk) disable iff (!rst_n) // see RL7
    (!cfg_q.sense[0] && !cfg_q.pol[0] && cfg_q.mask[0] && prev_q[0] && !sync2_q[0])
    |=> o_intr.line[0] ##1 !o_intr.line[0])
    else $error("falling edge on line zero gave no single interrupt pulse");
  chk_group_flag_set: assert property (@(posedge i_core_clk) disable iff (!rst_n) // see RL11
    (grp_hit != 12'h000) |=> (flags_q & $past(grp_hit)) == $past(grp_hit))
    else $error("enabled group hit did not set its flag");
  chk_flag_read_clear: assert property (@(posedge i_core_clk) disable iff (!rst_n) // see RL19
    (flag_read && grp_hit == 12'h000) |=> flags_q == 12'h000)
    else $error("group flags not cleared by read");
  chk_group_irq: assert property (@(posedge i_core_clk) disable iff (!rst_n) // see RL6
    (flags_q != 12'h000 && cfg_q.mask[BIT_GROUP]) |=> o_intr.group)
    else $error("pending flags with mask set gave no group interrupt");
  chk_trip_irq: assert property (@(posedge i_core_clk) disable iff (!rst_n) // see RL14
    s_sd_rise |=> o_intr.trip)
    else $error("shutdown did not raise the trip interrupt");
  chk_vector_map: assert property (@(posedge i_core_clk) disable iff (!rst_n) // see RL10
    (o_intr.line == 4'h8) |=> o_vector == 14'h0054 && o_vector_valid)
    else $error("line three interrupt gave wrong vector");
  chk_write_answer: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (aw_full_q && w_full_q && !o_bvalid) |=> o_bvalid)
    else $error("write response not given one cycle after address and data");

endmodule
